// [logic/mdm_pkg.sv]
// package for the monitor display and meters block
package mdm_pkg;
  // ******************************
  // register map (byte addresses)
  // ******************************
  localparam logic [7:0] ADDR_MONITOR_SELECT = 8'h00;
  localparam logic [7:0] ADDR_POWER_METER_CLEAR = 8'h04;
  localparam logic [7:0] ADDR_POWER_DIGIT_SHIFT = 8'h08;
  localparam logic [7:0] ADDR_RUN_HOURS_CLEAR = 8'h0C;
  localparam logic [7:0] ADDR_DECIMAL_DIGIT_SELECT = 8'h10;
  localparam logic [7:0] ADDR_POWER_ON_HOURS = 8'h14;
  localparam logic [7:0] ADDR_RUN_HOURS = 8'h18;
  localparam logic [7:0] ADDR_POWER_ON_HOURS_WRAP_COUNT = 8'h1C;
  localparam logic [7:0] ADDR_RUN_HOURS_WRAP_COUNT = 8'h20;
  localparam logic [7:0] ADDR_POWER_TOTAL = 8'h24;
  localparam logic [7:0] ADDR_POWER_COMM = 8'h28;
  localparam logic [7:0] ADDR_DISPLAY = 8'h2C;
  // ******************************
  // setting codes
  // ******************************
  localparam logic [15:0] SEL_SET_FREQ_STOP = 16'h0064;
  localparam logic [15:0] SEL_SET_FREQ_RAW = 16'h0005;
  localparam logic [15:0] SEL_UNIT_TERMINALS = 16'h0037;
  localparam logic [15:0] SEL_IN_OPTION = 16'h0038;
  localparam logic [15:0] SEL_OUT_OPTION = 16'h0039;
  localparam logic [15:0] SEL_POWER_ON_HOURS = 16'h0014;
  localparam logic [15:0] SEL_RUN_HOURS = 16'h0017;
  localparam logic [15:0] SEL_POWER_TOTAL = 16'h0019;
  localparam logic [15:0] SEL_SAVING_POWER = 16'h0033;
  localparam logic [15:0] VAL_NO_FUNCTION = 16'h270F;
  localparam logic [15:0] VAL_CLEAR = 16'h0000;
  localparam logic [15:0] VAL_COMM_LIMITED = 16'h000A;
  localparam logic [15:0] VAL_DEC_INTEGER = 16'h0000;
  localparam logic [15:0] VAL_DEC_ONE = 16'h0001;
  localparam logic [15:0] VAL_SHIFT_MAX = 16'h0004;
  // ******************************
  // reset values and limits
  // ******************************
  localparam logic [15:0] RST_MONITOR_SELECT = 16'h0000;
  localparam logic [15:0] RST_POWER_METER_CLEAR = 16'h270F;
  localparam logic [15:0] RST_POWER_DIGIT_SHIFT = 16'h270F;
  localparam logic [15:0] RST_DECIMAL_DIGIT_SELECT = 16'h270F;
  // power total in 0.01 kWh units, full scale 9999999.99 kWh
  localparam logic [39:0] POWER_MAX = 40'h00_3B9A_C9FF;
  localparam logic [15:0] HOURS_MAX = 16'hFFFF;
  // ******************************
  // timing
  // ******************************
  localparam longint HOUR_NS = 64'd3600000000000;
  localparam longint CLK_PERIOD_NS = 64'd5;
  localparam longint HOUR_CYCLES = HOUR_NS / CLK_PERIOD_NS;
  // ******************************
  // carriers
  // ******************************
  typedef struct packed {
    logic running;
    logic fault;
    logic output_shutoff_input;
    logic option_in_fitted;
    logic option_out_fitted;
    logic [15:0] set_freq;
    logic [15:0] limited_freq;
    logic [15:0] out_freq;
    logic [15:0] out_power;
    logic [7:0] unit_inputs;
    logic [7:0] unit_outputs;
    logic [7:0] option_inputs;
    logic [7:0] option_outputs;
  } mdm_drive_t;
  typedef struct packed {
    logic [31:0] value;
    logic [1:0] decimals;
    logic hz_led;
    logic [15:0] segments;
    logic [1:0] point;
  } mdm_display_t;
  typedef enum logic [2:0] {
    MDM_IDLE = 3'b001,
    MDM_WRITE = 3'b010,
    MDM_READ = 3'b100
  } mdm_bus_state_t;
endpackage : mdm_pkg

// [logic/mdm_top.sv]
// monitor selection, terminal monitor, power meter and hour counters
`timescale 1ns/1ps
// Functional notes
// - selection 100 shows set freq stopped
// - Hz led blinks stopped, steady running
// - stop value is limited frequency, not 5
// - fault shows frequency captured at fault
// - shutoff input displays like stopped
// - selections 55-57 show terminals on LEDs
// - segment lit when terminal on
// - 55 split rows; 56/57 light points
// - 56/57 accepted unfitted, segments off
// - power accumulates, display updates hourly
// - four or five digit power ranges
// - digit shift moves power right
// - clamp for 0-4, wrap for 9999
// - power clear reads 9999 or 10
// - power-on hourly, run hours only running
// - hour counters wrap, wraps counted
// - zero clears only run hours
// - run hours need full continuous hour
// - run clear reads 9999, 9999 no-op
// - decimal select 9999/0/1 behaviour
// - decimals fixed for meter monitors
module mdm_top
  import mdm_pkg::*;
#(
  parameter longint HOUR_TICKS = HOUR_CYCLES,
  parameter int BLINK_TICKS = 100000000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire mdm_drive_t drive,
  output mdm_display_t display
);
  // ******************************
  // state
  // ******************************
  typedef struct packed {
    mdm_bus_state_t bus;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [15:0] monitor_select;
    logic [15:0] power_meter_clear;
    logic [15:0] power_digit_shift;
    logic [15:0] decimal_digit_select;
    logic [63:0] hour_cnt;
    logic [63:0] run_cnt;
    logic [31:0] blink_cnt;
    logic blink;
    logic [15:0] fault_freq;
    logic fault_q;
    logic [39:0] power_acc;
    logic [39:0] power_shown;
    logic [15:0] power_on_hours;
    logic [15:0] run_hours;
    logic [15:0] power_on_wraps;
    logic [15:0] run_wraps;
    mdm_display_t disp;
  } mdm_state_t;
  mdm_state_t s;
  mdm_state_t next_s;
  // ******************************
  // derived values
  // ******************************
  logic hour_tick;
  logic run_hour_tick;
  logic stopped;
  logic [39:0] shifted;
  logic [39:0] sum;
  logic [15:0] wr16;
  logic do_write;
  logic [15:0] freq_now;
  always_comb begin
    hour_tick = (s.hour_cnt == 64'(HOUR_TICKS - 1));
    // run timer restarts on every stop so only whole continuous hours count
    run_hour_tick = drive.running && (s.run_cnt == 64'(HOUR_TICKS - 1));
    stopped = !drive.running || drive.output_shutoff_input;
    case (s.power_digit_shift)
      16'h0001: shifted = s.power_shown / 40'd10;
      16'h0002: shifted = s.power_shown / 40'd100;
      16'h0003: shifted = s.power_shown / 40'd1000;
      16'h0004: shifted = s.power_shown / 40'd10000;
      default: shifted = s.power_shown;
    endcase
    sum = s.power_acc + 40'(drive.out_power);
    wr16 = s.wdata[15:0];
    do_write = s.bus == MDM_WRITE;
    if (drive.fault && !s.fault_q) begin
      // capture cycle: the stored copy is not loaded yet
      freq_now = drive.out_freq;
    end else if (drive.fault) begin
      freq_now = s.fault_freq;
    end else begin
      freq_now = drive.out_freq;
    end
  end
  // ******************************
  // next state
  // ******************************
  always_comb begin
    next_s = s;
    s_axi_awready = (s.bus == MDM_IDLE) && !s.aw_got;
    s_axi_wready = (s.bus == MDM_IDLE) && !s.w_got;
    s_axi_arready = (s.bus == MDM_IDLE) && !s.aw_got && !s.w_got && !s_axi_awvalid;
    s_axi_bvalid = do_write;
    s_axi_rvalid = s.bus == MDM_READ;
    s_axi_bresp = s.bresp;
    s_axi_rresp = s.rresp;
    s_axi_rdata = s.rdata;
    // bus slave
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_got = 1'b1;
      next_s.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
    end
    if (s.bus == MDM_IDLE && s.aw_got && s.w_got) begin
      next_s.bus = MDM_WRITE;
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bresp = 2'b00;
      case (s.waddr)
        ADDR_MONITOR_SELECT: next_s.monitor_select = wr16;
        ADDR_POWER_DIGIT_SHIFT: next_s.power_digit_shift = wr16;
        ADDR_DECIMAL_DIGIT_SELECT: next_s.decimal_digit_select = wr16;
        ADDR_POWER_METER_CLEAR: begin
          if (wr16 == VAL_COMM_LIMITED) begin
            next_s.power_meter_clear = VAL_COMM_LIMITED;
          end else if (wr16 != VAL_CLEAR) begin
            next_s.power_meter_clear = VAL_NO_FUNCTION;
          end
        end
        ADDR_RUN_HOURS_CLEAR: ;
        default: next_s.bresp = 2'b10;
      endcase
    end else if (s_axi_arvalid && s_axi_arready) begin
      next_s.bus = MDM_READ;
      next_s.rresp = 2'b00;
      case (s_axi_araddr)
        ADDR_MONITOR_SELECT: next_s.rdata = {16'h0000, s.monitor_select};
        ADDR_POWER_METER_CLEAR: next_s.rdata = {16'h0000, s.power_meter_clear};
        ADDR_POWER_DIGIT_SHIFT: next_s.rdata = {16'h0000, s.power_digit_shift};
        ADDR_RUN_HOURS_CLEAR: next_s.rdata = {16'h0000, VAL_NO_FUNCTION};
        ADDR_DECIMAL_DIGIT_SELECT: next_s.rdata = {16'h0000, s.decimal_digit_select};
        ADDR_POWER_ON_HOURS: next_s.rdata = {16'h0000, s.power_on_hours};
        ADDR_RUN_HOURS: next_s.rdata = {16'h0000, s.run_hours};
        ADDR_POWER_ON_HOURS_WRAP_COUNT: next_s.rdata = {16'h0000, s.power_on_wraps};
        ADDR_RUN_HOURS_WRAP_COUNT: next_s.rdata = {16'h0000, s.run_wraps};
        ADDR_POWER_TOTAL: next_s.rdata = shifted[31:0];
        ADDR_POWER_COMM: begin
          // whole kWh for communication, limited range in mode 10
          if (s.power_meter_clear == VAL_COMM_LIMITED) begin
            next_s.rdata = 32'((shifted / 40'd100) % 40'd10000);
          end else begin
            next_s.rdata = {16'h0000, 16'((shifted / 40'd100) % 40'd65536)};
          end
        end
        ADDR_DISPLAY: next_s.rdata = s.disp.value;
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = 2'b10;
        end
      endcase
    end
    if (do_write && s_axi_bready) begin
      next_s.bus = MDM_IDLE;
    end
    if (s.bus == MDM_READ && s_axi_rready) begin
      next_s.bus = MDM_IDLE;
    end
    // time base
    next_s.hour_cnt = hour_tick ? 64'h0 : s.hour_cnt + 64'h1;
    if (!drive.running || run_hour_tick) begin
      next_s.run_cnt = 64'h0;
    end else begin
      next_s.run_cnt = s.run_cnt + 64'h1;
    end
    if (s.blink_cnt == 32'(BLINK_TICKS - 1)) begin
      next_s.blink_cnt = 32'h0;
      next_s.blink = !s.blink;
    end else begin
      next_s.blink_cnt = s.blink_cnt + 32'h1;
    end
    // fault capture on rising fault
    next_s.fault_q = drive.fault;
    if (drive.fault && !s.fault_q) begin
      next_s.fault_freq = drive.out_freq;
    end
    // power meter: sample each hour tick
    if (hour_tick) begin
      if (sum > POWER_MAX) begin
        if (s.power_digit_shift <= VAL_SHIFT_MAX) begin
          next_s.power_acc = POWER_MAX;
        end else begin
          next_s.power_acc = sum - POWER_MAX - 40'd1;
        end
      end else begin
        next_s.power_acc = sum;
      end
      next_s.power_shown = next_s.power_acc;
    end
    if (do_write && s.waddr == ADDR_POWER_METER_CLEAR && wr16 == VAL_CLEAR) begin
      next_s.power_acc = 40'h0;
      next_s.power_shown = 40'h0;
    end
    // hour meters
    if (hour_tick) begin
      next_s.power_on_hours = s.power_on_hours + 16'h1;
      if (s.power_on_hours == HOURS_MAX) begin
        next_s.power_on_wraps = s.power_on_wraps + 16'h1;
      end
    end
    if (run_hour_tick) begin
      next_s.run_hours = s.run_hours + 16'h1;
      if (s.run_hours == HOURS_MAX) begin
        next_s.run_wraps = s.run_wraps + 16'h1;
      end
    end
    if (do_write && s.waddr == ADDR_RUN_HOURS_CLEAR && wr16 == VAL_CLEAR) begin
      next_s.run_hours = 16'h0;
    end
    // display selection
    next_s.disp = '0;
    next_s.disp.decimals = 2'd2;
    case (s.monitor_select)
      SEL_SET_FREQ_STOP: begin
        if (stopped && !drive.fault) begin
          next_s.disp.value = {16'h0000, drive.limited_freq};
          next_s.disp.hz_led = s.blink;
        end else begin
          next_s.disp.value = {16'h0000, freq_now};
          next_s.disp.hz_led = 1'b1;
        end
      end
      SEL_SET_FREQ_RAW: next_s.disp.value = {16'h0000, drive.set_freq};
      SEL_UNIT_TERMINALS: begin
        next_s.disp.segments = {drive.unit_inputs, drive.unit_outputs};
      end
      SEL_IN_OPTION: begin
        next_s.disp.point = 2'b01;
        if (drive.option_in_fitted) begin
          next_s.disp.segments = {drive.option_inputs, 8'h00};
        end
      end
      SEL_OUT_OPTION: begin
        next_s.disp.point = 2'b10;
        if (drive.option_out_fitted) begin
          next_s.disp.segments = {8'h00, drive.option_outputs};
        end
      end
      SEL_POWER_ON_HOURS: begin
        next_s.disp.value = {16'h0000, s.power_on_hours};
        next_s.disp.decimals = 2'd0;
      end
      SEL_RUN_HOURS: begin
        next_s.disp.value = {16'h0000, s.run_hours};
        next_s.disp.decimals = 2'd0;
      end
      SEL_POWER_TOTAL: begin
        // panel range steps: 0.01 below 100, 0.1 below 1000, then 1 kWh
        next_s.disp.value = shifted[31:0];
        if (shifted < 40'd10000) begin
          next_s.disp.decimals = 2'd2;
        end else if (shifted < 40'd100000) begin
          next_s.disp.decimals = 2'd1;
        end else begin
          next_s.disp.decimals = 2'd0;
        end
      end
      default: next_s.disp.value = {16'h0000, freq_now};
    endcase
    // decimal digit trimming, skipped for the meter monitors
    if (s.monitor_select != SEL_POWER_ON_HOURS && s.monitor_select != SEL_RUN_HOURS &&
        s.monitor_select != SEL_POWER_TOTAL && s.monitor_select != SEL_SAVING_POWER) begin
      if (s.decimal_digit_select == VAL_DEC_INTEGER) begin
        if (next_s.disp.decimals == 2'd2) begin
          next_s.disp.value = next_s.disp.value / 32'd100;
        end else if (next_s.disp.decimals == 2'd1) begin
          next_s.disp.value = next_s.disp.value / 32'd10;
        end
        next_s.disp.decimals = 2'd0;
      end else if (s.decimal_digit_select == VAL_DEC_ONE && next_s.disp.decimals == 2'd2) begin
        next_s.disp.value = next_s.disp.value / 32'd10;
        next_s.disp.decimals = 2'd1;
      end
    end
    display = s.disp;
  end
  // ******************************
  // registers
  // ******************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.bus <= MDM_IDLE;
      s.monitor_select <= RST_MONITOR_SELECT;
      s.power_meter_clear <= RST_POWER_METER_CLEAR;
      s.power_digit_shift <= RST_POWER_DIGIT_SHIFT;
      s.decimal_digit_select <= RST_DECIMAL_DIGIT_SELECT;
    end else begin
      s <= next_s;
    end
  end
  // ******************************
  // assertions
  // ******************************
  property p_run_clear_read;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_RUN_HOURS_CLEAR)
      |=> (s_axi_rvalid && s_axi_rdata == 32'h0000_270F);
  endproperty
  a_run_clear_read: assert property (p_run_clear_read) else $error("run clear readback");
  property p_power_clear_read;
    @(posedge aclk) disable iff (!aresetn)
    s.power_meter_clear != 16'h0000;
  endproperty
  a_power_clear_read: assert property (p_power_clear_read) else $error("power clear is zero");
  property p_run_only_running;
    @(posedge aclk) disable iff (!aresetn)
    (!drive.running && !do_write) |=> $stable(s.run_hours);
  endproperty
  a_run_only_running: assert property (p_run_only_running) else $error("run hours moved");
  property p_power_on_hourly;
    @(posedge aclk) disable iff (!aresetn)
    hour_tick |=> (s.power_on_hours == $past(s.power_on_hours) + 16'h1);
  endproperty
  a_power_on_hourly: assert property (p_power_on_hourly) else $error("power-on hour miss");
  property p_wrap_count;
    @(posedge aclk) disable iff (!aresetn)
    (hour_tick && s.power_on_hours == 16'hFFFF)
      |=> (s.power_on_hours == 16'h0 && s.power_on_wraps == $past(s.power_on_wraps) + 16'h1);
  endproperty
  a_wrap_count: assert property (p_wrap_count) else $error("wrap not counted");
  property p_clamp;
    @(posedge aclk) disable iff (!aresetn)
    s.power_digit_shift <= 16'h0004 |-> s.power_acc <= POWER_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("power above max");
  property p_shown_hourly;
    @(posedge aclk) disable iff (!aresetn)
    (!hour_tick && !do_write) |=> $stable(s.power_shown);
  endproperty
  a_shown_hourly: assert property (p_shown_hourly) else $error("power shown moved");
  sequence s_unfitted_in;
    s.monitor_select == 16'h0038 && !drive.option_in_fitted;
  endsequence
  property p_unfitted;
    @(posedge aclk) disable iff (!aresetn)
    s_unfitted_in ##1 $stable(s.monitor_select) |-> s.disp.segments == 16'h0000;
  endproperty
  a_unfitted: assert property (p_unfitted) else $error("unfitted option lit");
  property p_hz_steady;
    @(posedge aclk) disable iff (!aresetn)
    (s.monitor_select == 16'h0064 && !stopped) |=> s.disp.hz_led;
  endproperty
  a_hz_steady: assert property (p_hz_steady) else $error("hz led not steady");
endmodule : mdm_top

// [tb/mdm_panel_model.sv]
// panel model that watches the display and counts lamp changes
`timescale 1ns/1ps
module mdm_panel_model
  import mdm_pkg::*;
(
  input wire logic aclk,
  input wire mdm_display_t display,
  output int blink_edges
);
  int count = 0;
  logic last_led = 1'b0;
  assign blink_edges = count;
  always @(posedge aclk) begin
    if (display.hz_led !== last_led) begin
      count <= count + 1;
    end
    last_led <= display.hz_led;
  end
endmodule : mdm_panel_model

// [tb/mdm_top_test.sv]
// self-checking bench for the monitor display and meters block
`timescale 1ns/1ps
module mdm_top_test;
  import mdm_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rv, a, b;
  mdm_drive_t drv = '0;
  mdm_display_t disp;
  int mismatches = 0, samples_checked = 0, blinks;
  always #2.5 aclk = ~aclk;
  mdm_top #(.HOUR_TICKS(20), .BLINK_TICKS(4)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .drive(drv), .display(disp));
  mdm_panel_model u_panel (.aclk(aclk), .display(disp), .blink_edges(blinks));
  // ******************************
  // bus and compare tasks
  // ******************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic at, wt, bt;
    bt = 1'b0;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bt) begin
      @(negedge aclk);
      at = awvalid && awready === 1'b1;
      wt = wvalid && wready === 1'b1;
      bt = bvalid === 1'b1;
      rs = bresp;
      @(posedge aclk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
      if (bt) bready <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    logic at, rt;
    rt = 1'b0;
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rt) begin
      @(negedge aclk);
      at = arvalid && arready === 1'b1;
      rt = rvalid === 1'b1;
      rv = rdata;
      rs = rresp;
      @(posedge aclk);
      if (at) arvalid <= 1'b0;
      if (rt) rready <= 1'b0;
    end
  endtask : rd
  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    rd(ad);
    check(rv, exp);
  endtask : rchk
  task automatic dchk(input logic [31:0] exp);
    repat_wait(3);
    check(disp.value, exp);
  endtask : dchk
  task automatic repat_wait(input int n);
    repeat (n) @(negedge aclk);
  endtask : repat_wait
  task automatic seg(input logic [15:0] s, input logic [1:0] p);
    repat_wait(3);
    check(disp.segments, s);
    check(disp.point, p);
  endtask : seg
  task automatic sync_tick;
    logic [31:0] v;
    @(negedge aclk);
    v = disp.value;
    while (disp.value === v) @(negedge aclk);
  endtask : sync_tick
  // ******************************
  // tests
  // ******************************
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(ADDR_MONITOR_SELECT, 32'h0);
    rchk(ADDR_POWER_METER_CLEAR, 32'h270F);
    rchk(ADDR_POWER_DIGIT_SHIFT, 32'h270F);
    rchk(ADDR_DECIMAL_DIGIT_SELECT, 32'h270F);
    rchk(8'h40, 32'h0);
    check(rs, 2'b10);
    wr(8'h40, 32'h1);
    check(rs, 32'h2);
    @(posedge aclk);
    drv.set_freq <= 16'h03E8;
    drv.limited_freq <= 16'h04D2;
    drv.out_freq <= 16'h022B;
    wr(ADDR_MONITOR_SELECT, 32'h64);
    dchk(32'h04D2);
    check(rs, 32'h0);
    wr(ADDR_MONITOR_SELECT, 32'h5);
    dchk(32'h03E8);
    wr(ADDR_MONITOR_SELECT, 32'h64);
    a = blinks;
    repat_wait(20);
    check(blinks > a + 1, 1'b1);
    @(posedge aclk);
    drv.running <= 1'b1;
    dchk(32'h022B);
    a = blinks;
    repat_wait(20);
    check(blinks - a, 32'h0);
    check(disp.hz_led, 1'b1);
    @(posedge aclk);
    drv.output_shutoff_input <= 1'b1;
    dchk(32'h04D2);
    @(posedge aclk);
    drv.output_shutoff_input <= 1'b0;
    drv.fault <= 1'b1;
    @(posedge aclk);
    drv.out_freq <= 16'h006F;
    dchk(32'h022B);
    @(posedge aclk);
    drv.fault <= 1'b0;
    drv.running <= 1'b0;
    wr(ADDR_DECIMAL_DIGIT_SELECT, 32'h0);
    dchk(32'h000C);
    check(disp.decimals, 32'h0);
    wr(ADDR_DECIMAL_DIGIT_SELECT, 32'h1);
    dchk(32'h007B);
    check(disp.decimals, 32'h1);
    wr(ADDR_DECIMAL_DIGIT_SELECT, 32'h0);
    @(posedge aclk);
    drv.limited_freq <= 16'h0063;
    dchk(32'h0);
    wr(ADDR_DECIMAL_DIGIT_SELECT, 32'h270F);
    dchk(32'h0063);
    check(disp.decimals, 32'h2);
    @(posedge aclk);
    drv.unit_inputs <= 8'hA5;
    drv.unit_outputs <= 8'h3C;
    drv.option_inputs <= 8'h5A;
    drv.option_outputs <= 8'hC3;
    wr(ADDR_MONITOR_SELECT, 32'h37);
    seg(16'hA53C, 2'b00);
    wr(ADDR_MONITOR_SELECT, 32'h38);
    seg(16'h0000, 2'b01);
    check(disp.segments, 16'h0);
    @(posedge aclk);
    drv.option_in_fitted <= 1'b1;
    seg(16'h5A00, 2'b01);
    wr(ADDR_MONITOR_SELECT, 32'h39);
    seg(16'h0000, 2'b10);
    check(disp.segments, 16'h0);
    @(posedge aclk);
    drv.option_out_fitted <= 1'b1;
    seg(16'h00C3, 2'b10);
    wr(ADDR_MONITOR_SELECT, 32'h14);
    wr(ADDR_DECIMAL_DIGIT_SELECT, 32'h0);
    sync_tick;
    a = disp.value;
    repat_wait(60);
    check(disp.value, a + 32'h3);
    rchk(ADDR_POWER_ON_HOURS, a + 32'h3);
    rd(ADDR_RUN_HOURS);
    b = rv;
    repeat (4) begin
      @(posedge aclk);
      drv.running <= 1'b1;
      repeat (15) @(posedge aclk);
      drv.running <= 1'b0;
      repeat (5) @(posedge aclk);
    end
    rchk(ADDR_RUN_HOURS, b);
    @(posedge aclk);
    drv.running <= 1'b1;
    repeat (65) @(posedge aclk);
    drv.running <= 1'b0;
    rchk(ADDR_RUN_HOURS, b + 32'h3);
    wr(ADDR_RUN_HOURS_CLEAR, 32'h270F);
    rchk(ADDR_RUN_HOURS, b + 32'h3);
    rchk(ADDR_RUN_HOURS_CLEAR, 32'h270F);
    rd(ADDR_POWER_ON_HOURS);
    a = rv;
    wr(ADDR_RUN_HOURS_CLEAR, 32'h0);
    rchk(ADDR_RUN_HOURS, 32'h0);
    rd(ADDR_POWER_ON_HOURS);
    check(rv >= a && rv > 32'h0, 1'b1);
    rchk(ADDR_RUN_HOURS_CLEAR, 32'h270F);
    wr(ADDR_POWER_DIGIT_SHIFT, 32'h0);
    sync_tick;
    @(posedge aclk);
    drv.out_power <= 16'h04D2;
    repeat (60) @(posedge aclk);
    drv.out_power <= 16'h0;
    rchk(ADDR_POWER_TOTAL, 32'h0E76);
    wr(ADDR_MONITOR_SELECT, 32'h19);
    dchk(32'h0E76);
    check(disp.decimals, 32'h2);
    rchk(ADDR_POWER_COMM, 32'h25);
    wr(ADDR_POWER_DIGIT_SHIFT, 32'h2);
    rchk(ADDR_POWER_TOTAL, 32'h25);
    dchk(32'h0025);
    wr(ADDR_POWER_METER_CLEAR, 32'h0);
    rchk(ADDR_POWER_TOTAL, 32'h0);
    rchk(ADDR_POWER_METER_CLEAR, 32'h270F);
    wr(ADDR_POWER_METER_CLEAR, 32'hA);
    rchk(ADDR_POWER_METER_CLEAR, 32'hA);
    wr(ADDR_POWER_METER_CLEAR, 32'h0);
    rchk(ADDR_POWER_METER_CLEAR, 32'hA);
    close_out;
  end
  initial begin
    #300000;
    mismatches++;
    close_out;
  end
endmodule : mdm_top_test
